// [ram_fifo_defs.svh]
// Purpose: Constants for the RAM ring FIFO unit
// Assumes: AHB-Lite register slave, 32-bit words
// Notes:   Offsets are byte addresses
`ifndef RAM_FIFO_DEFS_SVH
`define RAM_FIFO_DEFS_SVH
`define OFS_CONTROL   12'h000
`define OFS_BASE      12'h004
`define OFS_READ_PTR  12'h008
`define OFS_WRITE_PTR 12'h00c
`define OFS_TEMP_PTR  12'h010
`define OFS_STATUS    12'h014
`define OFS_COUNT     12'h018
`define CTL_RESET     32'h00000000
`define ST_RBOVF      0
`define ST_WBOVF      1
`define ST_FULL       2
`define ST_EMPTY      3
`define ST_OVR        4
`define ST_OVW        5
`define SIZE_SEL_W    3
`define PTR_W         16
`define MIN_SIZE_LOG2 4
`endif

// [ram_fifo_pkg.sv]
// Purpose: Types for the RAM ring FIFO unit
// Assumes: Included defs header
// Notes:   Types only
package ram_fifo_pkg;
   typedef enum logic [1:0] {
      TMP_NONE  = 2'h0,
      TMP_READ  = 2'h1,
      TMP_WRITE = 2'h2
   } temp_mode_t;
   typedef enum logic [1:0] {
      REQ_XFER   = 2'h0,
      REQ_MARK   = 2'h1,
      REQ_RELOAD = 2'h3
   } req_kind_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b11,
      ST_ACK  = 2'b10
   } xfer_state_t;
   typedef struct packed {
      logic       valid;
      req_kind_t  kind;
      logic       to_ram;
      logic [7:0] data;
   } periph_req_t;
   typedef struct packed {
      logic       ack;
      logic [7:0] data;
   } periph_rsp_t;
endpackage : ram_fifo_pkg

// [ram_fifo_ptr_step.sv]
// Purpose: Ring pointer step with wrap and boundary detect
// Assumes: Size is a power of two from size select
// Notes:   Pure combinational
`include "ram_fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ram_fifo_ptr_step #(
   parameter int PW = `PTR_W
) (
   input  wire logic [PW-1:0]              i_ptr,
   input  wire logic [`SIZE_SEL_W-1:0]     i_size_sel,
   output logic      [PW-1:0]              o_next,
   output logic                            o_boundary
);
   logic [PW-1:0] mask;
   logic [PW-1:0] sum;
   always_comb begin
      mask       = PW'((32'h1 << (`MIN_SIZE_LOG2 + 32'(i_size_sel))) - 32'h1);
      sum        = i_ptr + PW'(1);
      o_next     = sum & mask;
      o_boundary = (o_next == '0);
   end
endmodule : ram_fifo_ptr_step
`default_nettype wire

// [ram_fifo_unit.sv]
// Purpose: RAM ring FIFO unit: peripheral byte mover with AHB-Lite registers
// Assumes: Peripheral requests already synchronous; RAM is a byte port
// Notes:   One request in flight; ack pulses on completion
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`include "ram_fifo_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R1) Boundary event when pointer hits size boundary
// (R2) Read pointer reaching zero sets read flag
// (R3) Write pointer reaching zero sets write flag
// (R4) Software presets base and pointers per block
// (R5) Pointers wrap modulo selected FIFO size
// (R6) Software keeps accesses inside FIFO area
// (R7) Both directions allowed; software avoids errors
// (R8) USB uses two-byte endpoint buffers
// (R9) USB requests until max packet moved
// (R10) Mark or reload serviced after IN packet
// (R11) USB ends short on over-read
// (R12) USB underrun makes host NACK
// (R13) USB OUT requests whenever data present
// (R14) USB OUT ACK then mark request
// (R15) USB receive error gives NACK, reload
// (R16) Serial flags start transfer requests
// (R17) Card data enable starts requests
// (R18) Card pauses on empty, resumes
// (R19) Card pauses on full, continues
// (R20) Software reads from read pointer, count
// (R21) Software writes RAM then pointer
// (R22) Mark copies, reload restores temporary pointer
// (R23) Full and empty on pointer equality
// (R24) Events share two interrupt lines
// (R25) Pointer advances one per byte
module ram_fifo_unit #(
   parameter int PW = `PTR_W
) (
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_reset,
   input  wire logic                        hsel,
   input  wire logic [11:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   input  wire ram_fifo_pkg::periph_req_t   i_req,
   output ram_fifo_pkg::periph_rsp_t        o_rsp,
   output logic      [31:0]                 o_ram_addr,
   output logic                             o_ram_we,
   output logic                             o_ram_re,
   output logic      [7:0]                  o_ram_wdata,
   input  wire logic [7:0]                  i_ram_rdata,
   output logic                             o_irq_state,
   output logic                             o_irq_error
);
   logic [31:0]                     control_reg;
   logic [31:0]                     base_reg;
   logic [PW-1:0]                   fifo_read_pointer_reg;
   logic [PW-1:0]                   fifo_write_pointer_reg;
   logic [PW-1:0]                   temporary_pointer_reg;
   logic [5:0]                      fifo_status_reg;
   logic [PW-1:0]                   valid_byte_count_reg;
   ram_fifo_pkg::xfer_state_t       state_reg;
   ram_fifo_pkg::periph_req_t       cur_reg;
   logic                            wr_pend_reg;
   logic [11:0]                     addr_reg;
   logic [PW-1:0]                   rd_next;
   logic [PW-1:0]                   wr_next;
   logic                            rd_bound;
   logic                            wr_bound;
   logic [`SIZE_SEL_W-1:0]          fifo_size_select;
   ram_fifo_pkg::temp_mode_t        temp_mode;
   logic                            fifo_enable;
   logic                            sw_full_clr;
   logic                            sw_empty_clr;
   logic                            ev_rb, ev_wb, ev_full, ev_empty, ev_ovr, ev_ovw;

   // Control: [0] enable, [3:1] size select, [5:4] temp mode,
   // [6] clear empty, [7] clear full (self clearing strobes)
   assign fifo_enable      = control_reg[0];
   assign fifo_size_select = control_reg[3:1];
   assign temp_mode        = ram_fifo_pkg::temp_mode_t'(control_reg[5:4]);

   ram_fifo_ptr_step #(.PW(PW)) u_rd_step (
      .i_ptr      (fifo_read_pointer_reg),
      .i_size_sel (fifo_size_select),
      .o_next     (rd_next),
      .o_boundary (rd_bound)
   ); // [R5]
   ram_fifo_ptr_step #(.PW(PW)) u_wr_step (
      .i_ptr      (fifo_write_pointer_reg),
      .i_size_sel (fifo_size_select),
      .o_next     (wr_next),
      .o_boundary (wr_bound)
   ); // [R5]

   function automatic logic [31:0] ram_addr(input logic [31:0] base, input logic [PW-1:0] p);
      ram_addr = base | 32'(p);
   endfunction : ram_addr

   // AHB-Lite slave: zero-wait, always OKAY
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
      end else if (hready) begin
         wr_pend_reg <= hsel & htrans[1] & hwrite;
         addr_reg    <= haddr;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr == `OFS_CONTROL) begin
            hrdata <= control_reg;
         end else if (haddr == `OFS_BASE) begin
            hrdata <= base_reg;
         end else if (haddr == `OFS_READ_PTR) begin
            hrdata <= 32'(fifo_read_pointer_reg);
         end else if (haddr == `OFS_WRITE_PTR) begin
            hrdata <= 32'(fifo_write_pointer_reg);
         end else if (haddr == `OFS_TEMP_PTR) begin
            hrdata <= 32'(temporary_pointer_reg);
         end else if (haddr == `OFS_STATUS) begin
            hrdata <= 32'(fifo_status_reg);
         end else if (haddr == `OFS_COUNT) begin
            hrdata <= 32'(valid_byte_count_reg);
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   assign sw_empty_clr = wr_pend_reg && addr_reg == `OFS_CONTROL && hwdata[6];
   assign sw_full_clr  = wr_pend_reg && addr_reg == `OFS_CONTROL && hwdata[7];

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         control_reg <= `CTL_RESET;
         base_reg    <= 32'h00000000;
      end else if (wr_pend_reg) begin
         if (addr_reg == `OFS_CONTROL) begin
            control_reg <= {24'h000000, 2'b00, hwdata[5:0]};
         end else if (addr_reg == `OFS_BASE) begin
            base_reg <= hwdata;
         end
      end
   end

   // Transfer engine: take request, RAM cycle, acknowledge
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg <= ram_fifo_pkg::ST_IDLE;
         cur_reg   <= '0;
      end else begin
         case (state_reg)
            ram_fifo_pkg::ST_IDLE: begin
               if (i_req.valid && fifo_enable && !o_rsp.ack) begin
                  cur_reg   <= i_req;
                  state_reg <= (i_req.kind == ram_fifo_pkg::REQ_XFER) ?
                               ram_fifo_pkg::ST_ADDR : ram_fifo_pkg::ST_ACK;
               end
            end
            ram_fifo_pkg::ST_ADDR: state_reg <= ram_fifo_pkg::ST_DATA;
            ram_fifo_pkg::ST_DATA: state_reg <= ram_fifo_pkg::ST_ACK;
            default:               state_reg <= ram_fifo_pkg::ST_IDLE;
         endcase
      end
   end

   logic xfer_go;
   logic full_now, empty_now;
   assign xfer_go   = state_reg == ram_fifo_pkg::ST_ADDR;
   assign full_now  = fifo_status_reg[`ST_FULL];
   assign empty_now = fifo_status_reg[`ST_EMPTY];
   assign ev_ovr    = xfer_go && !cur_reg.to_ram && empty_now;
   assign ev_ovw    = xfer_go && cur_reg.to_ram && full_now;
   assign ev_rb     = xfer_go && !cur_reg.to_ram && !empty_now && rd_bound;   // [R2]
   assign ev_wb     = xfer_go && cur_reg.to_ram && !full_now && wr_bound;     // [R3]
   assign ev_empty  = xfer_go && !cur_reg.to_ram && !empty_now &&
                      rd_next == fifo_write_pointer_reg;                      // [R23]
   assign ev_full   = xfer_go && cur_reg.to_ram && !full_now &&
                      wr_next == fifo_read_pointer_reg;                       // [R23]

   // Pointers: software load, per-byte advance, mark and reload
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         fifo_read_pointer_reg  <= '0;
         fifo_write_pointer_reg <= '0;
         temporary_pointer_reg  <= '0;
      end else if (wr_pend_reg && addr_reg == `OFS_READ_PTR) begin
         fifo_read_pointer_reg <= hwdata[PW-1:0];
      end else if (wr_pend_reg && addr_reg == `OFS_WRITE_PTR) begin
         fifo_write_pointer_reg <= hwdata[PW-1:0];
      end else if (wr_pend_reg && addr_reg == `OFS_TEMP_PTR) begin
         temporary_pointer_reg <= hwdata[PW-1:0];
      end else if (xfer_go && !cur_reg.to_ram && !empty_now) begin
         fifo_read_pointer_reg <= rd_next;                                    // [R25]
      end else if (xfer_go && cur_reg.to_ram && !full_now) begin
         fifo_write_pointer_reg <= wr_next;                                   // [R25]
      end else if (state_reg == ram_fifo_pkg::ST_ACK) begin
         if (cur_reg.kind == ram_fifo_pkg::REQ_MARK) begin                    // [R22] [R10]
            if (temp_mode == ram_fifo_pkg::TMP_READ) begin
               temporary_pointer_reg <= fifo_read_pointer_reg;
            end else if (temp_mode == ram_fifo_pkg::TMP_WRITE) begin
               temporary_pointer_reg <= fifo_write_pointer_reg;
            end
         end else if (cur_reg.kind == ram_fifo_pkg::REQ_RELOAD) begin         // [R22] [R10]
            if (temp_mode == ram_fifo_pkg::TMP_READ) begin
               fifo_read_pointer_reg <= temporary_pointer_reg;
            end else if (temp_mode == ram_fifo_pkg::TMP_WRITE) begin
               fifo_write_pointer_reg <= temporary_pointer_reg;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         valid_byte_count_reg <= '0;
      end else begin
         valid_byte_count_reg <= (fifo_write_pointer_reg - fifo_read_pointer_reg) &
            PW'((32'h1 << (`MIN_SIZE_LOG2 + 32'(fifo_size_select))) - 32'h1);
      end
   end

   // Status: boundary and overrun flags sticky, write-one-to-clear; full and empty follow transfers; set wins over clear
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         fifo_status_reg <= 6'h08;
      end else begin
         fifo_status_reg[`ST_RBOVF] <= ev_rb | (fifo_status_reg[`ST_RBOVF] &
            ~(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_RBOVF])); // [R1] [R2]
         fifo_status_reg[`ST_WBOVF] <= ev_wb | (fifo_status_reg[`ST_WBOVF] &
            ~(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_WBOVF])); // [R1] [R3]
         fifo_status_reg[`ST_OVR] <= ev_ovr | (fifo_status_reg[`ST_OVR] &
            ~(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_OVR]));
         fifo_status_reg[`ST_OVW] <= ev_ovw | (fifo_status_reg[`ST_OVW] &
            ~(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_OVW]));
         fifo_status_reg[`ST_FULL]  <= ev_full | (full_now & ~sw_full_clr &
            ~(xfer_go && !cur_reg.to_ram && !empty_now) & fifo_enable);      // [R23]
         fifo_status_reg[`ST_EMPTY] <= ev_empty | ~fifo_enable | (empty_now & ~sw_empty_clr &
            ~(xfer_go && cur_reg.to_ram && !full_now));                      // [R23]
      end
   end

   // Two shared event lines
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_irq_state <= 1'b0;
         o_irq_error <= 1'b0;
      end else begin
         o_irq_state <= |fifo_status_reg[3:0];                                // [R24]
         o_irq_error <= |fifo_status_reg[5:4];                                // [R24]
      end
   end

   // RAM port and peripheral answer
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_ram_addr  <= 32'h00000000;
         o_ram_we    <= 1'b0;
         o_ram_re    <= 1'b0;
         o_ram_wdata <= 8'h00;
         o_rsp       <= '0;
      end else begin
         o_ram_we  <= xfer_go && cur_reg.to_ram && !full_now;
         o_ram_re  <= xfer_go && !cur_reg.to_ram && !empty_now;
         o_rsp.ack <= state_reg == ram_fifo_pkg::ST_ACK;
         if (xfer_go) begin
            o_ram_addr  <= ram_addr(base_reg, cur_reg.to_ram ?
                           fifo_write_pointer_reg : fifo_read_pointer_reg);
            o_ram_wdata <= cur_reg.data;
         end
         if (state_reg == ram_fifo_pkg::ST_DATA) begin
            o_rsp.data <= i_ram_rdata;
         end
      end
   end
endmodule : ram_fifo_unit
`default_nettype wire

// [ram_fifo_unit_properties.sv]
// Purpose: Port checker for the RAM ring FIFO unit
// Assumes: One clock, sync active-high reset
// Notes:   Bound to every instance of the unit
`timescale 1ns/10ps
`default_nettype none
module ram_fifo_unit_checker #(
   parameter int PW = 16
) (
   input wire logic                      i_clk_sys,
   input wire logic                      i_reset,
   input wire logic                      hsel,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire ram_fifo_pkg::periph_req_t i_req,
   input wire ram_fifo_pkg::periph_rsp_t o_rsp,
   input wire logic [31:0]               o_ram_addr,
   input wire logic                      o_ram_we,
   input wire logic                      o_ram_re,
   input wire logic [7:0]                o_ram_wdata,
   input wire logic                      o_irq_state
);
   logic [3:0] wait_q;
   logic [3:0] rd_last_q;
   logic [3:0] wr_last_q;
   logic       rd_ok_q;
   logic       wr_ok_q;
   logic       restart;
   // Pointer history is void after register writes or mark/reload
   assign restart = i_reset || (hsel && htrans[1] && hwrite)
                    || (o_rsp.ack && i_req.kind != ram_fifo_pkg::REQ_XFER);
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !i_req.valid) wait_q <= 4'h0;
      else if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
   end
   always_ff @(posedge i_clk_sys) begin
      rd_ok_q <= restart ? 1'b0 : (rd_ok_q || o_ram_re);
      if (o_ram_re) rd_last_q <= o_ram_addr[3:0];
   end
   always_ff @(posedge i_clk_sys) begin
      wr_ok_q <= restart ? 1'b0 : (wr_ok_q || o_ram_we);
      if (o_ram_we) wr_last_q <= o_ram_addr[3:0];
   end
   sequence s_strobe;
      o_ram_re || o_ram_we;
   endsequence
   sequence s_ack_later;
      ##2 o_rsp.ack;
   endsequence
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   a_xfer_ack_delay: assert property (
      o_rsp.ack && i_req.kind == ram_fifo_pkg::REQ_XFER |-> wait_q == 4'h4)
      else $error("transfer ack latency wrong");
   a_mark_ack_delay: assert property (
      o_rsp.ack && i_req.kind != ram_fifo_pkg::REQ_XFER |-> wait_q == 4'h2)
      else $error("mark or reload ack latency wrong");
   a_strobe_then_ack: assert property (s_strobe |-> s_ack_later)
      else $error("ram strobe without ack");
   a_strobe_single: assert property (s_strobe |=> !(o_ram_re || o_ram_we))
      else $error("ram strobe longer than one cycle");
   a_strobe_excl: assert property (!(o_ram_re && o_ram_we))
      else $error("ram read and write together");
   a_ack_single: assert property (o_rsp.ack |=> !o_rsp.ack)
      else $error("ack longer than one cycle");
   a_write_data: assert property (
      o_ram_we |-> $past(i_req.to_ram, 2) && o_ram_wdata == $past(i_req.data, 2))
      else $error("ram write data or direction wrong");
   a_read_dir: assert property (o_ram_re |-> !$past(i_req.to_ram, 2))
      else $error("ram read for write request");
   a_rd_ptr_step: assert property (
      o_ram_re && rd_ok_q |-> o_ram_addr[3:0] == rd_last_q + 4'h1)
      else $error("read pointer step wrong");
   a_wr_ptr_step: assert property (
      o_ram_we && wr_ok_q |-> o_ram_addr[3:0] == wr_last_q + 4'h1)
      else $error("write pointer step wrong");
   a_empty_at_start: assert property ($fell(i_reset) |-> ##[1:2] o_irq_state)
      else $error("empty state not flagged after reset");
endmodule : ram_fifo_unit_checker
bind ram_fifo_unit ram_fifo_unit_checker #(.PW(PW)) u_checker (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .i_req(i_req), .o_rsp(o_rsp), .o_ram_addr(o_ram_addr),
   .o_ram_we(o_ram_we), .o_ram_re(o_ram_re), .o_ram_wdata(o_ram_wdata),
   .o_irq_state(o_irq_state)
);
`default_nettype wire

// [periph_model.sv]
// Purpose: Peripheral requester model for the FIFO unit
// Assumes: Requests hold until ack is sampled
// Notes:   Released data line shows inverted byte
`timescale 1ns/10ps
`default_nettype none
module periph_model (
   input  wire ram_fifo_pkg::periph_rsp_t i_rsp,
   input  wire logic                      i_clk_sys,
   output var  ram_fifo_pkg::periph_req_t o_req
);
   initial o_req = '0;
   // Byte move, mark or reload, then release
   // One byte in flight, ack awaited for up to 64 cycles
   task automatic request(input ram_fifo_pkg::req_kind_t kind, input logic to_ram,
                          input logic [7:0] data, input int gap,
                          output logic [7:0] rdata, output logic acked);
      int n;
      repeat (gap) @(posedge i_clk_sys);
      o_req <= '{valid: 1'b1, kind: kind, to_ram: to_ram, data: data};
      n = 0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (i_rsp.ack !== 1'b1 && n < 64);
      acked = (i_rsp.ack === 1'b1);
      rdata = i_rsp.data;
      o_req <= '{valid: 1'b0, kind: kind, to_ram: to_ram, data: ~data};
   endtask : request
endmodule : periph_model
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the RAM ring FIFO unit
// Assumes: Byte RAM answers combinationally
// Notes:   Random sizes, bases, counts and data
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic                      i_clk_sys;
   logic                      i_reset;
   logic                      hsel;
   logic                      hwrite;
   logic [1:0]                htrans;
   logic [2:0]                hsize;
   logic [11:0]               haddr;
   logic [31:0]               hwdata;
   logic [31:0]               hrdata;
   logic                      hreadyout;
   logic                      hresp;
   ram_fifo_pkg::periph_req_t req;
   ram_fifo_pkg::periph_rsp_t rsp;
   logic [31:0]               ram_addr;
   logic                      ram_we;
   logic                      ram_re;
   logic [7:0]                ram_wdata;
   logic                      irq_state;
   logic                      irq_error;
   logic [7:0]                mem [0:1023];
   int                        err_count;
   int                        num_checks;
   ram_fifo_unit i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .i_req(req), .o_rsp(rsp), .o_ram_addr(ram_addr), .o_ram_we(ram_we),
      .o_ram_re(ram_re), .o_ram_wdata(ram_wdata), .i_ram_rdata(mem[ram_addr[9:0]]),
      .o_irq_state(irq_state), .o_irq_error(irq_error));
   periph_model u_per (.i_rsp(rsp), .i_clk_sys(i_clk_sys), .o_req(req));
   always @(posedge i_clk_sys) if (ram_we) mem[ram_addr[9:0]] <= ram_wdata;
   function automatic int ring(input int p, input int sz);
      return (p + 1) % sz;
   endfunction : ring
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, e);
   endtask : rd
   task automatic xfer(input ram_fifo_pkg::req_kind_t k, input logic to_ram,
                       input logic [7:0] d, output logic [7:0] q);
      logic ok;
      u_per.request(k, to_ram, d, 1 + $urandom_range(2), q, ok);
      chk(32'(ok), 32'h1);
   endtask : xfer
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      err_count++;
      finish_test();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] q;
      int         sel, sz, n, base, p;
      p = $urandom(32'hf6b89c30);
      err_count = 0;
      num_checks = 0;
      {i_reset, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 51'h0};
      repeat (4) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
      rd(12'h014, 32'h08);
      rd(12'h01c, 32'h00);
      $display("test reset done");
      sel = $urandom_range(1);
      sz = 16 << sel;
      base = $urandom_range(1, 15) * 64;
      n = $urandom_range(1, 8);
      for (int i = 0; i < sz; i++) mem[base + i] = 8'($urandom);
      wr(12'h004, base);
      wr(12'h008, sz - n);
      wr(12'h00c, 32'h0);
      wr(12'h000, 32'h01 | (sel << 1));
      wr(12'h000, 32'h41 | (sel << 1));
      rd(12'h018, n);
      p = sz - n;
      repeat (n) begin
         xfer(ram_fifo_pkg::REQ_XFER, 1'b0, 8'h0, q);
         chk(32'(q), 32'(mem[base + p]));
         p = ring(p, sz);
      end
      rd(12'h008, p);
      rd(12'h014, 32'h09);
      xfer(ram_fifo_pkg::REQ_XFER, 1'b0, 8'h0, q);
      rd(12'h014, 32'h19);
      chk(32'(irq_error), 32'h1);
      wr(12'h014, 32'h33);
      rd(12'h014, 32'h08);
      $display("test transmit block done");
      wr(12'h008, sz - n);
      wr(12'h00c, sz - n);
      wr(12'h000, 32'h01 | (sel << 1));
      p = sz - n;
      for (int i = 0; i < sz; i++) begin
         d = 8'($urandom);
         xfer(ram_fifo_pkg::REQ_XFER, 1'b1, d, q);
         chk(32'(mem[base + p]), 32'(d));
         p = ring(p, sz);
         if (i == n - 1) rd(12'h014, 32'h02);
      end
      rd(12'h014, 32'h06);
      xfer(ram_fifo_pkg::REQ_XFER, 1'b1, 8'ha5, q);
      rd(12'h014, 32'h26);
      chk(32'(irq_state & irq_error), 32'h1);
      $display("test receive block done");
      wr(12'h014, 32'h33);
      for (int m = 0; m < 3; m++) begin
         wr(12'h008, 32'h2);
         wr(12'h00c, 32'h6);
         wr(12'h000, 32'hc1 | (sel << 1) | (m << 4));
         xfer(ram_fifo_pkg::REQ_MARK, 1'b0, 8'h0, q);
         if (m != 0) rd(12'h010, (m == 1) ? 32'h2 : 32'h6);
         xfer(ram_fifo_pkg::REQ_XFER, m == 2, 8'h5a, q);
         xfer(ram_fifo_pkg::REQ_RELOAD, 1'b0, 8'h0, q);
         rd((m == 2) ? 12'h00c : 12'h008, (m == 0) ? 3 : ((m == 1) ? 2 : 6));
      end
      $display("test mark reload done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
